// [pkg/api_frame_regs.svh]
// Frame constants for the serial API status and receive frame builder.
`ifndef API_FRAME_REGS_SVH
`define API_FRAME_REGS_SVH

`define START_DELIM      8'h7E
`define TYPE_TX_STATUS   8'h89
`define TYPE_RX_ADDR64   8'h80
`define TYPE_RX_ADDR16   8'h81
`define ST_SUCCESS       8'h00
`define ST_NO_ACK        8'h01
`define ST_CCA_FAIL      8'h02
`define ST_INDIRECT      8'h03
`define ST_XCVR_FAIL     8'h04
`define ST_NET_ACK_FAIL  8'h21
`define ST_NOT_JOINED    8'h22
`define ST_INTERNAL      8'h31
`define ST_RESOURCE      8'h32
`define ST_TOO_LONG      8'h74
`define FMT_LEGACY       2'h2
`define SHORT_ADDR_NONE  16'hFFFE
`define OPT_BCAST_BIT    1
`define OPT_ALLPAN_BIT   2
`define LEN_TX_STATUS    16'h0003
`define LEN_RX64_BASE    16'h000B
`define LEN_RX16_BASE    16'h0005
`define ADDR64_BYTES     4'h8
`define ADDR16_BYTES     4'h2
`define CSUM_BASE        8'hFF

`endif

// [pkg/api_frame_pkg.sv]
// Types shared by the serial API frame builder.
package api_frame_pkg;

  typedef enum logic [3:0] {
    RES_SUCCESS,
    RES_NO_ACK,
    RES_CCA_FAIL,
    RES_INDIRECT,
    RES_XCVR_FAIL,
    RES_NET_ACK_FAIL,
    RES_NOT_JOINED,
    RES_INTERNAL,
    RES_RESOURCE,
    RES_TOO_LONG
  } txResult_t;

  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001,
    ST_DELIM = 12'h002,
    ST_LENH  = 12'h004,
    ST_LENL  = 12'h008,
    ST_TYPE  = 12'h010,
    ST_ID    = 12'h020,
    ST_STAT  = 12'h040,
    ST_ADDR  = 12'h080,
    ST_RSSI  = 12'h100,
    ST_OPTS  = 12'h200,
    ST_DATA  = 12'h400,
    ST_CSUM  = 12'h800
  } frameState_t;

endpackage

// [logic/byte_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,       // Module clock.
  input  wire logic             sys_rst,   // Synchronous reset, active high.
  input  wire logic             inValid,   // Writer offers a word.
  output logic                  inReady,   // FIFO has room.
  input  wire logic [WIDTH-1:0] inData,    // Word offered.
  output logic                  outValid,  // FIFO holds a word.
  input  wire logic             outReady,  // Reader takes the word.
  output logic      [WIDTH-1:0] outData    // Oldest word.
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    ptrInc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = (AW+1)'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_nxt = (AW+1)'(count_r - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= '0;
      inReady <= 1'b1;
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      count_r <= count_nxt;
      inReady <= (count_nxt != (AW+1)'(DEPTH));
      if (push) begin
        wrPtr_r <= ptrInc(wrPtr_r);
      end
      if (pop) begin
        rdPtr_r <= ptrInc(rdPtr_r);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule

// [logic/tx_status_encoder.sv]
// Maps a transmit outcome to its delivery status byte.
`timescale 1ns/1ps
module tx_status_encoder
  import api_frame_pkg::*;
(
  input  wire txResult_t   result,      // Outcome of the transmit request.
  input  wire logic        broadcast,   // Request was a broadcast.
  output logic       [7:0] statusByte   // Delivery status byte.
);
`include "api_frame_regs.svh"

  always_comb begin
    case (result)
      RES_SUCCESS:      statusByte = `ST_SUCCESS;
      RES_NO_ACK:       statusByte = `ST_NO_ACK;
      RES_CCA_FAIL:     statusByte = `ST_CCA_FAIL;
      RES_INDIRECT:     statusByte = `ST_INDIRECT;
      RES_XCVR_FAIL:    statusByte = `ST_XCVR_FAIL;
      RES_NET_ACK_FAIL: statusByte = `ST_NET_ACK_FAIL;
      RES_NOT_JOINED:   statusByte = `ST_NOT_JOINED;
      RES_INTERNAL:     statusByte = `ST_INTERNAL;
      RES_RESOURCE:     statusByte = `ST_RESOURCE;
      RES_TOO_LONG:     statusByte = `ST_TOO_LONG;
      default:          statusByte = `ST_INTERNAL;
    endcase
    // Broadcasts are never acknowledged, so any failure is hidden.
    if (broadcast) begin
      statusByte = `ST_SUCCESS;
    end
  end
endmodule

// [logic/api_status_rx_frame_builder.sv]
// Builds transmit status and legacy receive packet frames as a byte stream.
`timescale 1ns/1ps
module api_status_rx_frame_builder
  import api_frame_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk,              // Module clock, 250 MHz.
  input  wire logic        sys_rst,          // Synchronous reset, active high.
  input  wire logic [1:0]  apiOutputFormat,  // Output format setting.
  input  wire logic        txDoneValid,      // Transmit request completed.
  output logic             txDoneAck,        // Completion taken, one cycle.
  input  wire logic [7:0]  txFrameId,        // Identifier of the request.
  input  wire txResult_t   txResult,         // Outcome of the request.
  input  wire logic        txBroadcast,      // Request was a broadcast.
  input  wire logic        rxHdrValid,       // Received packet header offered.
  output logic             rxHdrAck,         // Header taken, one cycle.
  input  wire logic [63:0] rxSrcAddr64,      // Sender long address.
  input  wire logic [15:0] rxSrcAddr16,      // Sender short address.
  input  wire logic [15:0] ownShortAddress,  // This node's own short address setting.
  input  wire logic [7:0]  rxRssiDbm,        // Signal strength, signed dBm.
  input  wire logic        rxBroadcast,      // Packet was a broadcast.
  input  wire logic        rxAllPans,        // Broadcast across all PANs.
  input  wire logic [15:0] rxPayloadLen,     // Payload length in bytes.
  input  wire logic        rxDataValid,      // Payload byte offered.
  output logic             rxDataReady,      // Payload buffer has room.
  input  wire logic [7:0]  rxData,           // Payload byte.
  output logic             outValid,         // Frame byte valid.
  input  wire logic        outReady,         // Host takes the frame byte.
  output logic [7:0]       outData           // Frame byte.
);
`include "api_frame_regs.svh"

  frameState_t state_r;
  frameState_t state_nxt;
  logic        isRx_r;
  logic        is64_r;
  logic        drain_r;
  logic [7:0]  frameId_r;
  logic [7:0]  status_r;
  logic [63:0] addr_r;
  logic [3:0]  addrLeft_r;
  logic [7:0]  rssi_r;
  logic [7:0]  opts_r;
  logic [15:0] len_r;
  logic [15:0] dataLeft_r;
  logic [7:0]  sum_r;
  logic [7:0]  sum_nxt;
  logic [7:0]  byte_nxt;
  logic        valid_nxt;
  logic        advance;
  logic        takeTx;
  logic        dropTx;
  logic        takeRx;
  logic        legacy;
  logic        sender64;
  logic        fifoValid;
  logic        fifoPop;
  logic [7:0]  fifoData;
  logic [7:0]  statusEnc;

  // Payload bytes wait here until the header bytes have gone out.
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_payload_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (rxDataValid),
    .inReady  (rxDataReady),
    .inData   (rxData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // Status byte is worked out combinationally and captured when a completion is taken.
  tx_status_encoder u_status_enc (
    .result     (txResult),
    .broadcast  (txBroadcast),
    .statusByte (statusEnc)
  );

  // Magnitude of a signed dBm reading; positive readings clamp to zero.
  function automatic logic [7:0] rssiMagnitude(input logic [7:0] dbm);
    rssiMagnitude = dbm[7] ? 8'(~dbm + 8'h01) : 8'h00;
  endfunction

  // True for the states whose byte belongs to the checksummed body.
  function automatic logic inBody(input frameState_t s);
    case (s)
      ST_TYPE, ST_ID, ST_STAT, ST_ADDR, ST_RSSI, ST_OPTS, ST_DATA: begin
        inBody = 1'b1;
      end
      default: begin
        inBody = 1'b0;
      end
    endcase
  endfunction

  // Bytes of type, address, RSSI and options ahead of the payload.
  function automatic logic [15:0] rxBaseLen(input logic wide);
    rxBaseLen = wide ? `LEN_RX64_BASE : `LEN_RX16_BASE;
  endfunction

  // A new byte may be loaded when the output register is empty or being taken.
  assign advance  = !outValid || outReady;
  assign legacy   = (apiOutputFormat == `FMT_LEGACY);
  assign sender64 = (ownShortAddress == `SHORT_ADDR_NONE);
  // Requests are taken only when the last checksum byte has left or is leaving,
  // so that a stalled host never causes a captured request to be lost.
  assign takeTx   = (state_r == ST_IDLE) && !drain_r && advance && txDoneValid;
  assign dropTx   = takeTx && (txFrameId == 8'h00);
  assign takeRx   = (state_r == ST_IDLE) && !drain_r && advance && !txDoneValid
                    && rxHdrValid;
  assign fifoPop  = fifoValid && (drain_r || ((state_r == ST_DATA) && advance));

  always_comb begin
    state_nxt = state_r;
    byte_nxt  = outData;
    valid_nxt = outValid && !outReady;
    sum_nxt   = sum_r;
    if (advance) begin
      valid_nxt = 1'b1;
      case (state_r)
        ST_IDLE: begin
          valid_nxt = 1'b0;
          if ((takeTx && !dropTx) || (takeRx && legacy)) begin
            state_nxt = ST_DELIM;
          end
        end
        ST_DELIM: begin
          byte_nxt  = `START_DELIM;
          sum_nxt   = 8'h00;
          state_nxt = ST_LENH;
        end
        ST_LENH: begin
          byte_nxt  = len_r[15:8];
          state_nxt = ST_LENL;
        end
        ST_LENL: begin
          byte_nxt  = len_r[7:0];
          state_nxt = ST_TYPE;
        end
        ST_TYPE: begin
          if (!isRx_r) begin
            byte_nxt  = `TYPE_TX_STATUS;
            state_nxt = ST_ID;
          end else begin
            byte_nxt  = is64_r ? `TYPE_RX_ADDR64 : `TYPE_RX_ADDR16;
            state_nxt = ST_ADDR;
          end
        end
        ST_ID: begin
          byte_nxt  = frameId_r;
          state_nxt = ST_STAT;
        end
        ST_STAT: begin
          byte_nxt  = status_r;
          state_nxt = ST_CSUM;
        end
        // The address register shifts left, so its top byte is always next.
        ST_ADDR: begin
          byte_nxt = addr_r[63:56];
          if (addrLeft_r == 4'h1) begin
            state_nxt = ST_RSSI;
          end
        end
        ST_RSSI: begin
          byte_nxt  = rssi_r;
          state_nxt = ST_OPTS;
        end
        ST_OPTS: begin
          byte_nxt  = opts_r;
          state_nxt = (dataLeft_r == 16'h0000) ? ST_CSUM : ST_DATA;
        end
        // An empty payload buffer leaves a gap in the stream until a byte arrives.
        ST_DATA: begin
          byte_nxt  = fifoData;
          valid_nxt = fifoValid;
          if (fifoValid && (dataLeft_r == 16'h0001)) begin
            state_nxt = ST_CSUM;
          end
        end
        ST_CSUM: begin
          byte_nxt  = 8'(`CSUM_BASE - sum_r);
          state_nxt = ST_IDLE;
        end
        default: begin
          valid_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      endcase
      // Every byte after the length field and before the checksum is summed.
      if (valid_nxt && inBody(state_r)) begin
        sum_nxt = 8'(sum_r + byte_nxt);
      end
    end
  end

  // Frame sequencer state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Output byte register; it holds its byte while the host stalls.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outValid <= 1'b0;
    end else begin
      outValid <= valid_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outData <= 8'h00;
    end else begin
      outData <= byte_nxt;
    end
  end

  // Running body sum; it restarts when the delimiter is loaded.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sum_r <= 8'h00;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  // Each acknowledge is a single pulse in the cycle after the request is taken.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txDoneAck <= 1'b0;
    end else begin
      txDoneAck <= takeTx;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxHdrAck <= 1'b0;
    end else begin
      rxHdrAck <= takeRx;
    end
  end

  // Frame kind is fixed when a request is taken and held until the next one.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      isRx_r <= 1'b0;
      is64_r <= 1'b0;
    end else if (takeTx) begin
      isRx_r <= 1'b0;
    end else if (takeRx) begin
      isRx_r <= 1'b1;
      is64_r <= sender64;
    end
  end

  // Identifier and status of a completed request.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frameId_r <= 8'h00;
      status_r  <= 8'h00;
    end else if (takeTx) begin
      frameId_r <= txFrameId;
      status_r  <= statusEnc;
    end
  end

  // Signal strength and option flags of a received packet.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rssi_r <= 8'h00;
      opts_r <= 8'h00;
    end else if (takeRx) begin
      rssi_r <= rssiMagnitude(rxRssiDbm);
      opts_r <= 8'h00;
      opts_r[`OPT_BCAST_BIT]  <= rxBroadcast;
      opts_r[`OPT_ALLPAN_BIT] <= rxAllPans;
    end
  end

  // Length field; a payload length near the top of the range wraps.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      len_r <= 16'h0000;
    end else if (takeTx) begin
      len_r <= `LEN_TX_STATUS;
    end else if (takeRx) begin
      len_r <= 16'(rxBaseLen(sender64) + rxPayloadLen);
    end
  end

  // Address bytes leave most significant first.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_r <= 64'h0000_0000_0000_0000;
    end else if (takeRx) begin
      addr_r <= sender64 ? rxSrcAddr64 : {rxSrcAddr16, 48'h0000_0000_0000};
    end else if ((state_r == ST_ADDR) && advance) begin
      addr_r <= {addr_r[55:0], 8'h00};
    end
  end

  // Address bytes still to be sent.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addrLeft_r <= 4'h0;
    end else if (takeRx) begin
      addrLeft_r <= sender64 ? `ADDR64_BYTES : `ADDR16_BYTES;
    end else if ((state_r == ST_ADDR) && advance) begin
      addrLeft_r <= 4'(addrLeft_r - 4'h1);
    end
  end

  // Payload bytes still owed by the current packet.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataLeft_r <= 16'h0000;
    end else if (takeRx) begin
      dataLeft_r <= rxPayloadLen;
    end else if (fifoPop) begin
      dataLeft_r <= 16'(dataLeft_r - 16'h0001);
    end
  end

  // Payload of a packet that is not reported is drained and discarded.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drain_r <= 1'b0;
    end else if (takeRx) begin
      drain_r <= !legacy && (rxPayloadLen != 16'h0000);
    end else if (fifoPop && (dataLeft_r == 16'h0001)) begin
      drain_r <= 1'b0;
    end
  end
endmodule

// [test/api_frame_chk.sv]
// Concurrent checks on the frame builder ports.
`timescale 1ns/1ps
module api_frame_chk
  import api_frame_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic       clk,          // Module clock.
  input wire logic       sys_rst,      // Synchronous reset.
  input wire logic       txDoneValid,  // Completion offered.
  input wire logic       txDoneAck,    // Completion taken.
  input wire logic [7:0] txFrameId,    // Request identifier.
  input wire logic       txBroadcast,  // Broadcast request.
  input wire logic       rxHdrValid,   // Header offered.
  input wire logic       rxHdrAck,     // Header taken.
  input wire logic       outValid,     // Frame byte valid.
  input wire logic       outReady,     // Host takes the byte.
  input wire logic [7:0] outData       // Frame byte.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_txAck;
    txDoneAck |-> $past(txDoneValid) ##1 !txDoneAck;
  endproperty
  a_txAck: assert property (p_txAck)
    else $error("completion ack not a single pulse after a request");
  property p_rxAck;
    rxHdrAck |-> $past(rxHdrValid) && !txDoneAck ##1 !rxHdrAck;
  endproperty
  a_rxAck: assert property (p_rxAck)
    else $error("header ack not a single pulse after a header");
  property p_outHold;
    outValid && !outReady |=> outValid && $stable(outData);
  endproperty
  a_outHold: assert property (p_outHold)
    else $error("frame byte changed while host stalled");
  property p_txDelim;
    txDoneAck && !outValid && txFrameId != 8'h00 |=> outValid && outData == 8'h7E;
  endproperty
  a_txDelim: assert property (p_txDelim)
    else $error("status frame does not open with the delimiter");
  property p_zeroId;
    txDoneAck && !outValid && txFrameId == 8'h00 |=> !outValid;
  endproperty
  a_zeroId: assert property (p_zeroId)
    else $error("frame emitted for a zero identifier");
  property p_txLen;
    txDoneAck && !outValid && txFrameId != 8'h00 ##1 outReady[*2] |=> outData == 8'h03;
  endproperty
  a_txLen: assert property (p_txLen)
    else $error("status frame length low byte wrong");
  property p_txType;
    txDoneAck && !outValid && txFrameId != 8'h00 ##1 outReady[*3] |=> outData == 8'h89;
  endproperty
  a_txType: assert property (p_txType)
    else $error("status frame type byte wrong");
  property p_txId;
    txDoneAck && !outValid && txFrameId != 8'h00 ##1 outReady[*4]
      |=> outData == $past(txFrameId, 5);
  endproperty
  a_txId: assert property (p_txId)
    else $error("status frame identifier differs from request");
  property p_bcast;
    txDoneAck && !outValid && txFrameId != 8'h00 && txBroadcast ##1 outReady[*5]
      |=> outData == 8'h00;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast status not success");
endmodule

// [test/api_host_reader.sv]
// Host model that takes frame bytes and can stall two cycles in three.
`timescale 1ns/1ps
module api_host_reader (
  input  wire logic       clk,       // Module clock.
  input  wire logic       slow,      // Stall mode.
  input  wire logic       outValid,  // Frame byte valid.
  input  wire logic [7:0] outData,   // Frame byte.
  output logic            outReady   // Byte taken.
);
  logic [7:0] got[$];
  logic [1:0] phase_r;
  initial begin
    outReady = 1'b0;
    phase_r = 2'h0;
  end
  always @(negedge clk) begin
    phase_r = (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
    outReady = !slow || (phase_r == 2'h0);
  end
  always @(posedge clk) begin
    if (outValid && outReady) begin
      got.push_back(outData);
    end
  end
endmodule

// [test/api_status_rx_frame_builder_bench.sv]
// Bench for the frame builder with a host reader model.
`timescale 1ns/1ps
module api_status_rx_frame_builder_bench;
  import api_frame_pkg::*;
  logic        clk, sys_rst, txDoneValid, txDoneAck, txBroadcast, rxHdrValid, rxHdrAck;
  logic        rxBroadcast, rxAllPans, rxDataValid, rxDataReady, outValid, outReady;
  logic        slow, sawFull;
  logic [1:0]  apiOutputFormat;
  logic [7:0]  txFrameId, rxRssiDbm, rxData, outData;
  logic [15:0] rxSrcAddr16, ownShortAddress, rxPayloadLen;
  logic [63:0] rxSrcAddr64;
  txResult_t   txResult;
  logic [7:0]  exp[$];
  logic [7:0]  codes[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
                             8'h21, 8'h22, 8'h31, 8'h32, 8'h74};
  int          errTotal, samplesChecked;

  api_status_rx_frame_builder #(.FIFO_DEPTH(4)) api_status_rx_frame_builder_inst (
    .clk(clk), .sys_rst(sys_rst), .apiOutputFormat(apiOutputFormat),
    .txDoneValid(txDoneValid), .txDoneAck(txDoneAck), .txFrameId(txFrameId),
    .txResult(txResult), .txBroadcast(txBroadcast), .rxHdrValid(rxHdrValid),
    .rxHdrAck(rxHdrAck), .rxSrcAddr64(rxSrcAddr64), .rxSrcAddr16(rxSrcAddr16),
    .ownShortAddress(ownShortAddress), .rxRssiDbm(rxRssiDbm), .rxBroadcast(rxBroadcast),
    .rxAllPans(rxAllPans), .rxPayloadLen(rxPayloadLen), .rxDataValid(rxDataValid),
    .rxDataReady(rxDataReady), .rxData(rxData), .outValid(outValid),
    .outReady(outReady), .outData(outData));
  api_host_reader api_host_reader_inst (
    .clk(clk), .slow(slow), .outValid(outValid), .outData(outData), .outReady(outReady));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] want, input logic [7:0] seen);
    samplesChecked++;
    if (seen !== want) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Wraps a body in delimiter, length and checksum as the host expects it.
  task automatic frame(input logic [7:0] body[$]);
    logic [7:0] sum;
    sum = 8'h00;
    exp = {8'h7E, 8'h00, 8'(body.size())};
    foreach (body[i]) begin
      exp.push_back(body[i]);
      sum += body[i];
    end
    exp.push_back(8'hFF - sum);
  endtask

  task automatic expectFrame();
    int n;
    n = 0;
    while (api_host_reader_inst.got.size() < exp.size() && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (6) @(negedge clk);
    check8("frame size", 8'(exp.size()), 8'(api_host_reader_inst.got.size()));
    foreach (exp[i]) check8("frame byte", exp[i], api_host_reader_inst.got[i]);
    api_host_reader_inst.got.delete();
  endtask

  task automatic txStatus(input logic [7:0] id, input txResult_t res, input logic bc,
                          input logic [7:0] st);
    int n;
    n = 0;
    @(negedge clk);
    txFrameId = id;
    txResult = res;
    txBroadcast = bc;
    txDoneValid = 1'b1;
    while (!txDoneAck && n < 50) begin
      @(negedge clk);
      n++;
    end
    txDoneValid = 1'b0;
    check8("tx ack", 8'h01, {7'h00, txDoneAck});
    exp.delete();
    if (id != 8'h00) frame({8'h89, id, st});
    expectFrame();
  endtask

  task automatic rxPacket(input logic [15:0] own, input logic [7:0] rssi, input logic bc,
                          input logic ap, input int len, input logic legacy);
    int n;
    logic [7:0] body[$];
    n = 0;
    @(negedge clk);
    apiOutputFormat = legacy ? 2'h2 : 2'h1;
    ownShortAddress = own;
    rxRssiDbm = rssi;
    rxBroadcast = bc;
    rxAllPans = ap;
    rxPayloadLen = 16'(len);
    rxHdrValid = 1'b1;
    while (!rxHdrAck && n < 50) begin
      @(negedge clk);
      n++;
    end
    rxHdrValid = 1'b0;
    check8("rx ack", 8'h01, {7'h00, rxHdrAck});
    n = 0;
    while (n < len) begin
      rxDataValid = 1'b1;
      rxData = 8'h40 + 8'(n);
      if (rxDataReady) n++;
      else sawFull = 1'b1;
      @(negedge clk);
    end
    rxDataValid = 1'b0;
    body = {8'h81, rxSrcAddr16[15:8], rxSrcAddr16[7:0]};
    if (own == 16'hFFFE) begin
      body = {8'h80};
      for (int i = 7; i >= 0; i--) body.push_back(rxSrcAddr64[i*8 +: 8]);
    end
    body.push_back(rssi[7] ? 8'h00 - rssi : 8'h00);
    body.push_back({5'h00, ap, bc, 1'b0});
    for (int i = 0; i < len; i++) body.push_back(8'h40 + 8'(i));
    exp.delete();
    if (legacy) frame(body);
    expectFrame();
  endtask

  initial begin
    sys_rst = 1'b1;
    {txDoneValid, txBroadcast, rxHdrValid, rxBroadcast, rxAllPans, rxDataValid} = '0;
    {slow, sawFull, txFrameId, rxRssiDbm, rxData, ownShortAddress, rxPayloadLen} = '0;
    apiOutputFormat = 2'h2;
    txResult = RES_SUCCESS;
    rxSrcAddr64 = 64'h0013A20087654321;
    rxSrcAddr16 = 16'h1234;
    errTotal = 0;
    samplesChecked = 0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    txStatus(8'h52, RES_SUCCESS, 1'b0, 8'h00);
    for (int r = 0; r < 10; r++) txStatus(8'(r + 1), txResult_t'(r), 1'b0, codes[r]);
    txStatus(8'h33, RES_NO_ACK, 1'b1, 8'h00);
    txStatus(8'h00, RES_CCA_FAIL, 1'b0, 8'h00);
    rxPacket(16'hFFFE, 8'hD8, 1'b1, 1'b0, 3, 1'b1);
    slow = 1'b1;
    rxPacket(16'hFFFD, 8'hA2, 1'b0, 1'b1, 9, 1'b1);
    check8("payload refused", 8'h01, {7'h00, sawFull});
    slow = 1'b0;
    rxPacket(16'h1234, 8'h10, 1'b1, 1'b1, 2, 1'b0);
    txStatus(8'hFF, RES_TOO_LONG, 1'b0, 8'h74);
    finishTest();
  end

  initial begin
    #40000;
    errTotal++;
    finishTest();
  end
endmodule

bind api_status_rx_frame_builder api_frame_chk #(.FIFO_DEPTH(FIFO_DEPTH)) api_frame_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .txDoneValid(txDoneValid), .txDoneAck(txDoneAck),
  .txFrameId(txFrameId), .txBroadcast(txBroadcast), .rxHdrValid(rxHdrValid),
  .rxHdrAck(rxHdrAck), .outValid(outValid), .outReady(outReady), .outData(outData));
